// ### pkg/rpx_pkg.sv
/*
 * Constants for the eight-bit relay port expander: register pointers,
 * reset values, slave addresses and bus timing.
 * Assumes the includer imports the package whole.
 */
`default_nettype none

package rpx_pkg;

    // --------------------------------------------------------------
    // Register pointers
    // --------------------------------------------------------------
    localparam logic [7:0] RPX_PTR_INPUT    = 8'h00;
    localparam logic [7:0] RPX_PTR_OUTPUT   = 8'h01;
    localparam logic [7:0] RPX_PTR_POLARITY = 8'h02;
    localparam logic [7:0] RPX_PTR_DIR      = 8'h03;
    localparam logic [1:0] RPX_PTR_MASK     = 2'h3;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RPX_RST_OUTPUT   = 8'hff;
    localparam logic [7:0] RPX_RST_POLARITY = 8'h00;
    localparam logic [7:0] RPX_RST_DIR      = 8'hff;
    localparam logic [7:0] RPX_RST_POINTER  = 8'h00;

    // --------------------------------------------------------------
    // Slave addresses
    // --------------------------------------------------------------
    localparam logic [6:0] RPX_ADDR_STRAP_LOW  = 7'h20;
    localparam logic [6:0] RPX_ADDR_STRAP_HIGH = 7'h21;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int RPX_CLK_MHZ      = 125;
    localparam int RPX_BUS_MAX_KHZ  = 400;
    localparam int RPX_SYNC_STAGES  = 2;

    typedef enum logic [2:0] {
        RPX_ST_IDLE,
        RPX_ST_ADDR,
        RPX_ST_ADDR_ACK,
        RPX_ST_WRITE,
        RPX_ST_WRITE_ACK,
        RPX_ST_READ,
        RPX_ST_READ_ACK
    } rpx_state_t;

endpackage : rpx_pkg

`default_nettype wire

// ### hdl/rpx_sync.sv
/*
 * Two-stage synchroniser for a vector of levels.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rpx_sync
    import rpx_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    initial begin
        if (WIDTH < 1) begin
            $error("rpx_sync width must be positive");
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_q <= INIT;
            syncOut  <= INIT;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule : rpx_sync

`default_nettype wire

// ### hdl/rpx_expander.sv
/*
 * Eight-bit port expander behind a two-wire serial slave, feeding a
 * low-side relay driver array.
 * Assumes scl is the link clock; sda is sampled on the scl domain with
 * start and stop caught by edges of sda. Port pins and strap are async.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R01] Serial slave up to fast-mode speed with eight general-purpose port pins.
// [R02] Four eight-bit registers: direction, input, output, polarity inversion.
// [R03] After power-up every pin is an input until direction is written.
// [R04] Master writes a direction bit per pin; expander applies that direction.
// [R05] Input register holds sampled pin levels; output pins drive output register.
// [R06] Set polarity bit reports the inverse of that pin's level.
// [R07] All four registers are readable over the bus.
// [R08] Power-on loads register defaults and initialises the bus state machine.
// [R09] Active-low reset pin gives the same reset as power-on.
// [R10] Open-drain low interrupt asserts when any input differs from stored state.
// [R11] Slave address 0x20 with strap low, 0x21 with strap high.
// [R12] Undriven relay input reads low and keeps the switch off.
// [R13] Relay channel sinks coil current when its input is driven high.
// [R14] Interrupt releases on input register read or inputs returning.
module rpx_expander
    import rpx_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            resetPinN,
    input  wire logic            addrStrap,
    input  wire logic            sclClk,
    input  wire logic            sdaIn,
    output var  logic            sdaOut,
    output var  logic            sdaOe,
    input  wire logic [PINS-1:0] portIn,
    output var  logic [PINS-1:0] portOut,
    output var  logic [PINS-1:0] portOe,
    output var  logic [PINS-1:0] relayOn,
    output var  logic            intN,
    output var  logic            intOe
);

    initial begin
        if (PINS != 8) begin
            $error("rpx_expander serves exactly eight pins");
        end
    end

    // ------------------------------------------------------------------
    // Reset and synchronised pins (clk domain)
    // ------------------------------------------------------------------
    logic            resetPinNSync;
    logic            strapSync;
    logic [PINS-1:0] pinSync;
    logic            rstAll;

    rpx_sync #(.WIDTH(PINS + 2), .INIT({1'b1, 1'b0, {PINS{1'b0}}})) uSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .asyncIn ({resetPinN, addrStrap, portIn}),
        .syncOut ({resetPinNSync, strapSync, pinSync})
    );

    assign rstAll = sys_rst | ~resetPinNSync; // R08 R09

    // ------------------------------------------------------------------
    // Link domain: start/stop detect on sda edges
    // ------------------------------------------------------------------
    // Start toggles on sda fall while scl high; stop on sda rise.
    logic startTog_q;
    logic stopTog_q;
    logic linkRst1_q;
    logic linkRst_q;

    // Sda edges are the only clock here, so clear from the link reset
    always_ff @(negedge sdaIn or posedge linkRst_q) begin
        if (linkRst_q) begin
            startTog_q <= 1'b0;
        end else if (sclClk) begin
            startTog_q <= ~startTog_q;
        end
    end

    always_ff @(posedge sdaIn or posedge linkRst_q) begin
        if (linkRst_q) begin
            stopTog_q <= 1'b0;
        end else if (sclClk) begin
            stopTog_q <= ~stopTog_q;
        end
    end

    // Start/stop toggles seen in the scl domain
    logic startSeen_q;
    logic stopSeen_q;

    // Reset crossing into scl domain (level, two stages)
    always_ff @(posedge sclClk) begin
        linkRst1_q <= rstAll;
        linkRst_q  <= linkRst1_q;
    end

    // ------------------------------------------------------------------
    // Link domain: byte engine on scl
    // ------------------------------------------------------------------
    rpx_state_t      state_q;
    logic [2:0]      bitCnt_q;
    logic [7:0]      shift_q;
    logic            firstData_q;
    logic [1:0]      ptr_q;
    logic [7:0]      wrData_q;
    logic [1:0]      wrAddr_q;
    logic            wrTog_q;
    logic            rdInTog_q;
    logic [7:0]      rdData;
    logic [6:0]      myAddr;
    logic [7:0]      dirSnap;
    logic [7:0]      outSnap;
    logic [7:0]      polSnap;
    logic [7:0]      inSnap;

    assign myAddr = strapSync ? RPX_ADDR_STRAP_HIGH : RPX_ADDR_STRAP_LOW; // R11

    always_comb begin
        case (ptr_q)
            RPX_PTR_INPUT[1:0]:    rdData = inSnap;
            RPX_PTR_OUTPUT[1:0]:   rdData = outSnap;
            RPX_PTR_POLARITY[1:0]: rdData = polSnap;
            default:               rdData = dirSnap; // R07
        endcase
    end

    always_ff @(posedge sclClk) begin
        if (linkRst_q) begin
            state_q     <= RPX_ST_IDLE; // R08 R09
            bitCnt_q    <= 3'h0;
            shift_q     <= 8'h00;
            firstData_q <= 1'b0;
            ptr_q       <= RPX_RST_POINTER[1:0];
            wrData_q    <= 8'h00;
            wrAddr_q    <= 2'h0;
            wrTog_q     <= 1'b0;
            rdInTog_q   <= 1'b0;
            startSeen_q <= startTog_q;
            stopSeen_q  <= stopTog_q;
        end else if (startSeen_q != startTog_q) begin
            startSeen_q <= startTog_q;
            stopSeen_q  <= stopTog_q;
            state_q     <= RPX_ST_ADDR;
            bitCnt_q    <= 3'h6;
            shift_q     <= {7'h00, sdaIn};
        end else if (stopSeen_q != stopTog_q) begin
            stopSeen_q <= stopTog_q;
            state_q    <= RPX_ST_IDLE;
        end else begin
            case (state_q)
                RPX_ST_ADDR: begin
                    shift_q  <= {shift_q[6:0], sdaIn};
                    bitCnt_q <= bitCnt_q - 3'h1;
                    if (bitCnt_q == 3'h0) begin
                        if (shift_q[6:0] == myAddr) begin // R01 R11
                            state_q <= RPX_ST_ADDR_ACK;
                        end else begin
                            state_q <= RPX_ST_IDLE;
                        end
                    end
                end
                RPX_ST_ADDR_ACK: begin
                    bitCnt_q    <= 3'h7;
                    firstData_q <= 1'b1;
                    if (shift_q[0]) begin
                        state_q <= RPX_ST_READ;
                        shift_q <= rdData; // R07
                        if (ptr_q == RPX_PTR_INPUT[1:0]) begin
                            rdInTog_q <= ~rdInTog_q; // R14
                        end
                    end else begin
                        state_q <= RPX_ST_WRITE;
                        shift_q <= 8'h00;
                    end
                end
                RPX_ST_WRITE: begin
                    shift_q  <= {shift_q[6:0], sdaIn};
                    bitCnt_q <= bitCnt_q - 3'h1;
                    if (bitCnt_q == 3'h0) begin
                        state_q <= RPX_ST_WRITE_ACK;
                    end
                end
                RPX_ST_WRITE_ACK: begin
                    bitCnt_q    <= 3'h7;
                    state_q     <= RPX_ST_WRITE;
                    firstData_q <= 1'b0;
                    if (firstData_q) begin
                        ptr_q <= shift_q[1:0] & RPX_PTR_MASK;
                    end else begin
                        wrData_q <= shift_q; // R04
                        wrAddr_q <= ptr_q;
                        wrTog_q  <= ~wrTog_q;
                    end
                end
                RPX_ST_READ: begin
                    shift_q  <= {shift_q[6:0], 1'b0};
                    bitCnt_q <= bitCnt_q - 3'h1;
                    if (bitCnt_q == 3'h0) begin
                        state_q <= RPX_ST_READ_ACK;
                    end
                end
                RPX_ST_READ_ACK: begin
                    bitCnt_q <= 3'h7;
                    if (sdaIn) begin
                        state_q <= RPX_ST_IDLE;
                    end else begin
                        state_q <= RPX_ST_READ;
                        shift_q <= rdData;
                        if (ptr_q == RPX_PTR_INPUT[1:0]) begin
                            rdInTog_q <= ~rdInTog_q; // R14
                        end
                    end
                end
                default: begin
                    state_q <= RPX_ST_IDLE;
                end
            endcase
        end
    end

    // Drive sda on falling scl so it is stable through scl high
    always_ff @(negedge sclClk) begin
        if (linkRst_q) begin
            sdaOut <= 1'b0;
            sdaOe  <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            sdaOe  <= (state_q == RPX_ST_ADDR_ACK) || (state_q == RPX_ST_WRITE_ACK)
                   || ((state_q == RPX_ST_READ) && !shift_q[7]);
        end
    end

    // ------------------------------------------------------------------
    // Crossing of write events and register snapshots
    // ------------------------------------------------------------------
    logic [2:0] wrTogSync_q;
    logic [2:0] rdTogSync_q;
    logic [7:0] dir_q; // R02
    logic [7:0] out_q;
    logic [7:0] pol_q;
    logic [7:0] inReg_q;
    logic       wrEvent;
    logic       rdEvent;

    always_ff @(posedge clk) begin
        if (rstAll) begin
            wrTogSync_q <= 3'h0;
            rdTogSync_q <= 3'h0;
        end else begin
            wrTogSync_q <= {wrTogSync_q[1:0], wrTog_q};
            rdTogSync_q <= {rdTogSync_q[1:0], rdInTog_q};
        end
    end

    assign wrEvent = wrTogSync_q[2] ^ wrTogSync_q[1];
    assign rdEvent = rdTogSync_q[2] ^ rdTogSync_q[1];

    // Payload set on the same scl edge as its toggle, so stable for two clk cycles before wrEvent and for the rest of the byte
    always_ff @(posedge clk) begin
        if (rstAll) begin
            dir_q <= RPX_RST_DIR; // R03
            out_q <= RPX_RST_OUTPUT;
            pol_q <= RPX_RST_POLARITY;
        end else if (wrEvent) begin
            case (wrAddr_q)
                RPX_PTR_OUTPUT[1:0]:   out_q <= wrData_q;
                RPX_PTR_POLARITY[1:0]: pol_q <= wrData_q;
                RPX_PTR_DIR[1:0]:      dir_q <= wrData_q; // R04
                default:               ;
            endcase
        end
    end

    // Snapshots read by the scl domain; dir, output and polarity stable between bus writes, input follows the pins
    assign dirSnap = dir_q;
    assign outSnap = out_q;
    assign polSnap = pol_q;
    assign inSnap  = inReg_q;

    // ------------------------------------------------------------------
    // Input register, change interrupt
    // ------------------------------------------------------------------
    logic [7:0] pinView;
    logic [7:0] seenRef_q;
    logic       mismatch;
    logic       intPend_q;

    assign pinView  = pinSync ^ pol_q; // R06
    assign mismatch = |((pinView ^ seenRef_q) & dir_q); // R10

    // Input register follows the pins
    always_ff @(posedge clk) begin
        if (rstAll) begin
            inReg_q <= 8'h00;
        end else begin
            inReg_q <= pinView; // R05
        end
    end

    // Input state as last read; a change from it holds the interrupt
    always_ff @(posedge clk) begin
        if (rstAll) begin
            seenRef_q <= 8'h00;
        end else if (rdEvent) begin
            seenRef_q <= pinView; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (rstAll) begin
            intPend_q <= 1'b0;
        end else if (rdEvent) begin
            intPend_q <= 1'b0; // R14
        end else begin
            intPend_q <= mismatch; // R10 R14
        end
    end

    // ------------------------------------------------------------------
    // Pins, relay drive, interrupt pin
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < PINS; i++) begin : gPin
            always_ff @(posedge clk) begin
                if (rstAll) begin
                    portOut[i] <= 1'b0;
                    portOe[i]  <= 1'b0; // R03
                    relayOn[i] <= 1'b0;
                end else begin
                    portOut[i] <= out_q[i]; // R05
                    portOe[i]  <= ~dir_q[i]; // R04
                    relayOn[i] <= ~dir_q[i] & out_q[i]; // R12 R13
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rstAll) begin
            intN  <= 1'b0;
            intOe <= 1'b0;
        end else begin
            intN  <= 1'b0;
            intOe <= intPend_q; // R10
        end
    end

endmodule : rpx_expander

`default_nettype wire

// ### dv/rpx_props.sv
/* Port checker for rpx_expander.
   Assumes a bind onto rpx_expander, sampled on clk. */
`timescale 1ns/1ps
`default_nettype none
module rpx_props #(
    parameter int PINS = 8
) (
    input wire logic            clk,
    input wire logic            sys_rst,
    input wire logic            resetPinN,
    input wire logic            addrStrap,
    input wire logic            sclClk,
    input wire logic            sdaIn,
    input wire logic            sdaOut,
    input wire logic            sdaOe,
    input wire logic [PINS-1:0] portIn,
    input wire logic [PINS-1:0] portOut,
    input wire logic [PINS-1:0] portOe,
    input wire logic [PINS-1:0] relayOn,
    input wire logic            intN,
    input wire logic            intOe
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_sdaLow; sdaOut == 1'b0; endproperty
    a_sdaLow: assert property (p_sdaLow) else $error("sda driven high");
    property p_sdaHold; sclClk && $past(sclClk) |-> $stable(sdaOe); endproperty
    a_sdaHold: assert property (p_sdaHold) else $error("sda moved with scl high");
    property p_intLow; intN == 1'b0; endproperty
    a_intLow: assert property (p_intLow) else $error("interrupt driven high");
    property p_relay; $stable(portOe & portOut) [*3] |-> relayOn == (portOe & portOut); endproperty
    a_relay: assert property (p_relay) else $error("relay not driven level");
    property p_relaySub; (relayOn & ~portOe) == '0; endproperty
    a_relaySub: assert property (p_relaySub) else $error("relay on for undriven pin");
    property p_pinReset; !resetPinN [*5] |-> portOe == '0 && relayOn == '0 && !intOe; endproperty
    a_pinReset: assert property (p_pinReset) else $error("reset pin ignored");
    property p_rstRel; disable iff (1'b0) $fell(sys_rst) |-> portOe == '0 && relayOn == '0 && !intOe; endproperty
    a_rstRel: assert property (p_rstRel) else $error("pins not inputs after reset");
    property p_allOut; &portOe [*8] |-> !intOe; endproperty
    a_allOut: assert property (p_allOut) else $error("interrupt without input pins");
    c_int: cover property ($rose(intOe));
    c_ack: cover property ($rose(sdaOe));
    c_relay: cover property (relayOn != '0);
endmodule : rpx_props
`default_nettype wire

// ### dv/rpx_master.sv
/* Bus master model driving scl and pulling sda.
   Assumes sda has a pull-up and scl rests high between frames. */
`timescale 1ns/1ps
`default_nettype none
module rpx_master (
    output var  logic sclClk,
    output var  logic sdaPull,
    input  wire logic sdaLine
);
    // ----------------------------------------------------------
    // Bit level, 80 ns scl period
    // ----------------------------------------------------------
    localparam time Q = 20ns;
    initial begin
        sclClk = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic idleClocks(input int n);
        repeat (n) begin
            #Q sclClk = 1'b0;
            #(2*Q) sclClk = 1'b1;
            #Q;
        end
    endtask : idleClocks
    task automatic startBit;
        #7 sdaPull = 1'b1;
        #Q sclClk = 1'b0;
        #Q;
    endtask : startBit
    task automatic bitIo(input logic b, output logic s);
        sdaPull = !b;
        #Q sclClk = 1'b1;
        #Q s = sdaLine;
        #Q sclClk = 1'b0;
        #Q;
    endtask : bitIo
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
        for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
        bitIo(ackIn, ackOut);
    endtask : xfer
    task automatic stopBit;
        sdaPull = 1'b1;
        #Q sclClk = 1'b1;
        #Q sdaPull = 1'b0;
        #(2*Q);
    endtask : stopBit
endmodule : rpx_master
`default_nettype wire

// ### dv/test_i2c_relay_port_expander.sv
/* Self-checking bench for rpx_expander with a bus master model.
   Assumes rpx_pkg is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_i2c_relay_port_expander
    import rpx_pkg::*;
;
    logic       clk, sys_rst, resetPinN, addrStrap, sclClk, sdaPull, sdaOut, sdaOe, intN, intOe, nakExp;
    logic [7:0] ext, portOut, portOe, relayOn;
    logic [6:0] devAddr;
    wire        sdaLine = !(sdaPull || sdaOe);
    wire  [7:0] portIn = (portOe & portOut) | (~portOe & ext);
    int         badCount, checked, cycles;
    rpx_expander i_rpx_expander (.clk(clk), .sys_rst(sys_rst), .resetPinN(resetPinN), .addrStrap(addrStrap),
        .sclClk(sclClk), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .portIn(portIn), .portOut(portOut),
        .portOe(portOe), .relayOn(relayOn), .intN(intN), .intOe(intOe));
    rpx_master i_rpx_master (.sclClk(sclClk), .sdaPull(sdaPull), .sdaLine(sdaLine));
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        logic k0, k1, k2;
        i_rpx_master.startBit();
        i_rpx_master.xfer({devAddr, 1'b0}, 1'b1, r, k0);
        i_rpx_master.xfer(p, 1'b1, r, k1);
        i_rpx_master.xfer(d, 1'b1, r, k2);
        i_rpx_master.stopBit();
        chk({5'h0, k0, k1, k2}, nakExp ? 8'h07 : 8'h00);
        repeat (8) @(posedge clk);
        #1;
    endtask : wr
    task automatic rc(input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] r, d;
        logic k0, k1, k2, n;
        i_rpx_master.startBit();
        i_rpx_master.xfer({devAddr, 1'b0}, 1'b1, r, k0);
        i_rpx_master.xfer(p, 1'b1, r, k1);
        i_rpx_master.stopBit();
        i_rpx_master.startBit();
        i_rpx_master.xfer({devAddr, 1'b1}, 1'b1, r, k2);
        i_rpx_master.xfer(8'hff, 1'b1, d, n);
        i_rpx_master.stopBit();
        chk({5'h0, k0, k1, k2}, 8'h00);
        chk(d, exp);
        repeat (8) @(posedge clk);
        #1;
    endtask : rc
    task automatic setExt(input logic [7:0] v);
        @(posedge clk);
        #1 ext = v;
    endtask : setExt
    task automatic waitInt(input logic v);
        for (int n = 0; n < 40 && intOe !== v; n++) @(posedge clk);
        repeat (8) @(posedge clk);
        #1 chk({7'h0, intOe}, {7'h0, v});
    endtask : waitInt
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        chk(portOe, 8'h00);
        chk(relayOn, 8'h00);
        rc(RPX_PTR_DIR, 8'hff);
        rc(RPX_PTR_OUTPUT, RPX_RST_OUTPUT);
        rc(RPX_PTR_POLARITY, 8'h00);
    endtask : t_reset
    task automatic t_outputs;
        wr(RPX_PTR_DIR, 8'h0f);
        wr(RPX_PTR_OUTPUT, 8'h5a);
        chk(portOe, 8'hf0);
        chk(portOut, 8'h5a);
        chk(relayOn, 8'h50);
        rc(RPX_PTR_DIR, 8'h0f);
        rc(RPX_PTR_OUTPUT, 8'h5a);
    endtask : t_outputs
    task automatic t_polarity;
        setExt(8'h3c);
        wr(RPX_PTR_POLARITY, 8'h99);
        rc(RPX_PTR_POLARITY, 8'h99);
        rc(RPX_PTR_INPUT, 8'hc5);
    endtask : t_polarity
    task automatic t_interrupt;
        setExt(8'h3d);
        waitInt(1'b1);
        setExt(8'h3c);
        waitInt(1'b0);
        setExt(8'h3d);
        waitInt(1'b1);
        rc(RPX_PTR_INPUT, 8'hc4);
        waitInt(1'b0);
    endtask : t_interrupt
    task automatic t_address;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            #1 addrStrap = s[0];
            repeat (8) @(posedge clk);
            devAddr = s[0] ? 7'h20 : 7'h21;
            nakExp = 1'b1;
            wr(RPX_PTR_OUTPUT, 8'h00);
            chk(portOut, s[0] ? 8'ha5 : 8'h5a);
            devAddr = s[0] ? 7'h21 : 7'h20;
            nakExp = 1'b0;
            wr(RPX_PTR_OUTPUT, 8'ha5 ^ {7'h0, s[0]});
            chk(portOut, 8'ha5 ^ {7'h0, s[0]});
        end
    endtask : t_address
    task automatic t_resetPin;
        @(posedge clk);
        #1 resetPinN = 1'b0;
        i_rpx_master.idleClocks(3);
        chk(portOe, 8'h00);
        chk(relayOn, 8'h00);
        resetPinN = 1'b1;
        i_rpx_master.idleClocks(2);
        rc(RPX_PTR_DIR, 8'hff);
        rc(RPX_PTR_OUTPUT, 8'hff);
        wr(RPX_PTR_DIR, 8'h00);
        chk(relayOn, 8'hff);
        repeat (12) @(posedge clk);
    endtask : t_resetPin
    // ----------------------------------------------------------
    // Clock, timeout, sequence
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            badCount++;
            conclude();
        end
    end
    initial begin
        {sys_rst, resetPinN, addrStrap, nakExp, ext, devAddr} = {3'b110, 1'b0, 8'h00, 7'h20};
        // Link reset needs scl edges while reset is held
        fork
            i_rpx_master.idleClocks(3);
            begin
                repeat (16) @(posedge clk);
                #1 sys_rst = 1'b0;
            end
        join
        i_rpx_master.idleClocks(2);
        t_reset();
        t_outputs();
        t_polarity();
        t_interrupt();
        t_address();
        t_resetPin();
        conclude();
    end
endmodule : test_i2c_relay_port_expander
bind rpx_expander rpx_props #(.PINS(PINS)) i_rpx_props (.clk(clk), .sys_rst(sys_rst), .resetPinN(resetPinN),
    .addrStrap(addrStrap), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .portIn(portIn),
    .portOut(portOut), .portOe(portOe), .relayOn(relayOn), .intN(intN), .intOe(intOe));
`default_nettype wire
